// ---- common/pdm_defines.vh ----
// Register map, field layout and reset values of the power-down controller.
// Assumes the includer uses an 8-bit APB byte address.
`ifndef PDM_DEFINES_VH
`define PDM_DEFINES_VH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define PDM_ADDR_STOP_A   8'h00
`define PDM_ADDR_STOP_B   8'h04
`define PDM_ADDR_STOP_C   8'h08
`define PDM_ADDR_CLK_CTRL 8'h0c
`define PDM_ADDR_SBY_CTRL 8'h10
`define PDM_ADDR_STATUS   8'h14

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PDM_RST_STOP_A    8'h3f
`define PDM_RST_STOP_B    8'hff
`define PDM_RST_STOP_C    8'hff
`define PDM_RST_CLK_SEL   3'h0
`define PDM_RST_SBY_CTRL  8'h08

// ------------------------------------------------------------
// Standby control field positions
// ------------------------------------------------------------
`define PDM_SBY_SEL_BIT   7
`define PDM_SBY_SET_HI    6
`define PDM_SBY_SET_LO    4
`define PDM_SBY_RSV_BIT   3

// ------------------------------------------------------------
// Settling wait and divider limits
// ------------------------------------------------------------
`define PDM_SETTLE_BASE   20'd8192
`define PDM_SETTLE_MAXC   3'h5
`define PDM_DIV_MAXC      3'h5

`endif

// ---- hw/pdm_clk_div.v ----
// Bus master clock enable divider: one pulse every 2**sel cycles, codes above 5 taken as 5.
// Assumes sel changes only at a bus cycle boundary.
`timescale 1ns/1ns
`include "pdm_defines.vh"

module pdm_clk_div (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       sync_clr,
  input  wire [2:0] div_sel,
  output wire       tick
);

  // ------------------------------------------------------------
  // Ratio and counter
  // ------------------------------------------------------------
  reg  [4:0] cnt_r;     // Cycles since last tick
  reg  [2:0] sel_q_r;   // Ratio in use
  wire [2:0] sel_c;     // Clamped code
  wire [4:0] last_c;    // Terminal count

  // Codes above the top ratio clamp to divide by 32
  assign sel_c  = (div_sel > `PDM_DIV_MAXC) ? `PDM_DIV_MAXC : div_sel;
  assign last_c = (5'h01 << sel_c) - 5'h01;

  // Tick at terminal count, every cycle at code 0
  assign tick = (cnt_r == last_c);

  // Counter restarts on a ratio change so no short period leaks out
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r   <= 5'h00;
      sel_q_r <= 3'h0;
    end else if (sync_clr || (sel_c != sel_q_r)) begin
      cnt_r   <= 5'h00;
      sel_q_r <= sel_c;
    end else if (tick) begin
      cnt_r <= 5'h00;
    end else begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

endmodule

// ---- hw/pdm_ctrl.v ----
// Power-down controller: module stop, medium speed, sleep, standby.
// Assumes one 100 MHz clock, APB master, pins sampled on pclk.
`timescale 1ns/1ns
`include "pdm_defines.vh"

module pdm_ctrl #(
  parameter [19:0] SETTLE_BASE = `PDM_SETTLE_BASE
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        bus_cycle_end,
  input  wire        sleep_req,
  input  wire        int_req,
  input  wire        int_enabled,
  input  wire        cpu_int_masked,
  input  wire        nmi_req,
  input  wire [5:0]  external_interrupt_lines,
  input  wire [5:0]  ext_int_enable,
  input  wire [5:0]  ext_int_to_xfer,
  input  wire        reset_pin_n,
  input  wire        wdt_overflow,
  input  wire        hardware_standby_pin_n,
  input  wire [23:0] periph_req,
  output wire [23:0] periph_grant,
  output wire [7:0]  module_stop_a,
  output wire [7:0]  module_stop_b,
  output wire [7:0]  module_stop_c,
  output wire        bm_clk_en,
  output wire        periph_clk_en,
  output wire        cpu_halt,
  output wire        osc_enable,
  output wire        serial_standby_clr,
  output reg         int_exc_start,
  output reg         reset_exc_start,
  output wire        chip_reset,
  output wire        hw_standby
);

  // ------------------------------------------------------------
  // Mode states, one-hot
  // ------------------------------------------------------------
  localparam [5:0] ST_RUN    = 6'h01;  // Program execution
  localparam [5:0] ST_SLEEP  = 6'h02;  // CPU halted
  localparam [5:0] ST_SBY    = 6'h04;  // Oscillator stopped
  localparam [5:0] ST_SETTLE = 6'h08;  // Oscillator settling
  localparam [5:0] ST_RESET  = 6'h10;  // Reset state
  localparam [5:0] ST_HWSBY  = 6'h20;  // Hardware standby

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg  [7:0]  stop_a_r;     // Written stop bits A
  reg  [7:0]  stop_b_r;     // Written stop bits B
  reg  [7:0]  stop_c_r;     // Written stop bits C
  reg  [7:0]  eff_a_r;      // Stop bits in force A
  reg  [7:0]  eff_b_r;      // Stop bits in force B
  reg  [7:0]  eff_c_r;      // Stop bits in force C
  reg  [2:0]  clk_sel_r;    // Written divide select
  reg  [2:0]  div_act_r;    // Divide select in force
  reg         sby_sel_r;    // Sleep goes to standby
  reg  [2:0]  settle_r;     // Settling wait code
  reg         sby_rsv_r;    // Spare read/write bit
  reg  [5:0]  state_r;      // Mode state
  reg  [5:0]  state_nxt;    // Next mode state
  reg  [19:0] wait_r;       // Settling countdown
  reg  [19:0] wait_nxt;     // Next countdown

  // ------------------------------------------------------------
  // Wake and reset conditions
  // ------------------------------------------------------------
  wire        int_rst;      // Reset state request
  wire        sleep_wake;   // Interrupt ends sleep
  wire        sby_wake;     // Interrupt ends standby
  wire [5:0]  ext_ok;       // External lines allowed to wake
  wire [2:0]  set_c;        // Clamped settle code
  wire [19:0] settle_load;  // Settling states
  wire        wr_en;        // APB write strobe
  wire        rd_setup;     // APB read setup
  wire        addr_ok;      // Mapped address
  wire        div_tick;     // Divided master tick
  wire [23:0] stop_all;     // Stop bits in force

  // Reset pin, watchdog and standby pin all return the control registers to reset values
  assign int_rst = !reset_pin_n || wdt_overflow ||
                   !hardware_standby_pin_n;

  // Enabled interrupt ends sleep; NMI ignores CPU mask
  assign sleep_wake = nmi_req ||
                      (int_req && int_enabled &&
                       !cpu_int_masked);

  // External line wakes only if enabled, unmasked, not to transfer
  assign ext_ok = external_interrupt_lines & ext_int_enable &
                  ~ext_int_to_xfer;
  assign sby_wake = nmi_req ||
                    ((|ext_ok) && !cpu_int_masked);

  // Reserved and unusable codes fall back to the longest wait
  assign set_c = (settle_r > `PDM_SETTLE_MAXC) ?
                 `PDM_SETTLE_MAXC : settle_r;
  assign settle_load = SETTLE_BASE << set_c;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign addr_ok  = (paddr == `PDM_ADDR_STOP_A)   ||
                    (paddr == `PDM_ADDR_STOP_B)   ||
                    (paddr == `PDM_ADDR_STOP_C)   ||
                    (paddr == `PDM_ADDR_CLK_CTRL) ||
                    (paddr == `PDM_ADDR_SBY_CTRL) ||
                    (paddr == `PDM_ADDR_STATUS);

  // No wait states; unmapped access errors
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // All control fields return to reset values in the reset state
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_a_r  <= `PDM_RST_STOP_A;
      stop_b_r  <= `PDM_RST_STOP_B;
      stop_c_r  <= `PDM_RST_STOP_C;
      clk_sel_r <= `PDM_RST_CLK_SEL;
      sby_sel_r <= 1'b0;
      settle_r  <= 3'h0;
      sby_rsv_r <= 1'b1;
    end else if (int_rst) begin
      stop_a_r  <= `PDM_RST_STOP_A;
      stop_b_r  <= `PDM_RST_STOP_B;
      stop_c_r  <= `PDM_RST_STOP_C;
      clk_sel_r <= `PDM_RST_CLK_SEL;
      sby_sel_r <= 1'b0;
      settle_r  <= 3'h0;
      sby_rsv_r <= 1'b1;
    end else if (wr_en) begin
      // Every stop bit is plain read/write
      if (paddr == `PDM_ADDR_STOP_A) begin
        stop_a_r <= pwdata[7:0];
      end else if (paddr == `PDM_ADDR_STOP_B) begin
        stop_b_r <= pwdata[7:0];
      end else if (paddr == `PDM_ADDR_STOP_C) begin
        stop_c_r <= pwdata[7:0];
      end else if (paddr == `PDM_ADDR_CLK_CTRL) begin
        clk_sel_r <= pwdata[2:0];
      end else if (paddr == `PDM_ADDR_SBY_CTRL) begin
        sby_sel_r <= pwdata[`PDM_SBY_SEL_BIT];
        settle_r  <= pwdata[`PDM_SBY_SET_HI:`PDM_SBY_SET_LO];
        sby_rsv_r <= pwdata[`PDM_SBY_RSV_BIT];
      end
    end
  end

  // ------------------------------------------------------------
  // Bus cycle boundary updates
  // ------------------------------------------------------------
  // Stop bits and divide ratio change only at the end of a cycle or on a pin or watchdog reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eff_a_r   <= `PDM_RST_STOP_A;
      eff_b_r   <= `PDM_RST_STOP_B;
      eff_c_r   <= `PDM_RST_STOP_C;
      div_act_r <= `PDM_RST_CLK_SEL;
    end else if (int_rst) begin
      eff_a_r   <= `PDM_RST_STOP_A;
      eff_b_r   <= `PDM_RST_STOP_B;
      eff_c_r   <= `PDM_RST_STOP_C;
      div_act_r <= `PDM_RST_CLK_SEL;
    end else if (bus_cycle_end) begin
      eff_a_r   <= stop_a_r;
      eff_b_r   <= stop_b_r;
      eff_c_r   <= stop_c_r;
      div_act_r <= clk_sel_r;
    end
  end

  assign module_stop_a = eff_a_r;
  assign module_stop_b = eff_b_r;
  assign module_stop_c = eff_c_r;
  assign stop_all      = {eff_c_r, eff_b_r, eff_a_r};

  // ------------------------------------------------------------
  // Peripheral register access gating
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 24; gi = gi + 1) begin : g_gate
      // A stopped module refuses register access
      assign periph_grant[gi] = periph_req[gi] &&
                                !stop_all[gi];
    end
  endgenerate

  // ------------------------------------------------------------
  // Bus master clock enable
  // ------------------------------------------------------------
  pdm_clk_div u_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .sync_clr (int_rst),
    .div_sel  (div_act_r),
    .tick     (div_tick)
  );

  // Masters step on the divided enable; ratio survives sleep and software standby
  assign bm_clk_en = div_tick && (state_r == ST_RUN);

  // ------------------------------------------------------------
  // Mode state machine
  // ------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    wait_nxt  = wait_r;
    case (state_r)
      ST_RUN: begin
        // Sleep request picks sleep or standby
        if (sleep_req) begin
          if (sby_sel_r) begin
            state_nxt = ST_SBY;
          end else begin
            state_nxt = ST_SLEEP;
          end
        end
      end
      ST_SLEEP: begin
        // Wake by interrupt
        if (sleep_wake) begin
          state_nxt = ST_RUN;
        end
      end
      ST_SBY: begin
        // Restart oscillator and load settling wait
        if (sby_wake) begin
          state_nxt = ST_SETTLE;
          wait_nxt  = settle_load - 20'd1;
        end
      end
      ST_SETTLE: begin
        // Count settling states
        if (wait_r == 20'd0) begin
          state_nxt = ST_RUN;
        end else begin
          wait_nxt = wait_r - 20'd1;
        end
      end
      ST_RESET: begin
        // Leave once the pin is released
        state_nxt = ST_RUN;
      end
      ST_HWSBY: begin
        // Standby pin high moves on to reset state
        state_nxt = ST_RESET;
      end
      default: begin
        state_nxt = ST_RESET;
      end
    endcase
    // Pins override every mode
    if (!hardware_standby_pin_n) begin
      state_nxt = ST_HWSBY;
      wait_nxt  = 20'd0;
    end else if (!reset_pin_n || wdt_overflow) begin
      state_nxt = ST_RESET;
      wait_nxt  = 20'd0;
    end
  end

  // State, countdown and exception pulses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r         <= ST_RESET;
      wait_r          <= 20'd0;
      int_exc_start   <= 1'b0;
      reset_exc_start <= 1'b0;
    end else begin
      state_r <= state_nxt;
      wait_r  <= wait_nxt;
      // Interrupt handling begins on wake into run
      int_exc_start <= ((state_r == ST_SLEEP) ||
                        (state_r == ST_SETTLE)) &&
                       (state_nxt == ST_RUN);
      // Reset handling begins on release of reset state
      reset_exc_start <= (state_r == ST_RESET) &&
                         (state_nxt == ST_RUN);
    end
  end

  // ------------------------------------------------------------
  // Mode outputs
  // ------------------------------------------------------------
  // CPU stops in sleep and standby, keeps state
  assign cpu_halt = (state_r == ST_SLEEP) ||
                    (state_r == ST_SBY)   ||
                    (state_r == ST_SETTLE);

  // Peripheral clock runs in sleep, stops in standby
  assign periph_clk_en = (state_r == ST_RUN) ||
                         (state_r == ST_SLEEP) ||
                         (state_r == ST_RESET);

  // Oscillator off only in software and hardware standby
  assign osc_enable = !((state_r == ST_SBY) ||
                        (state_r == ST_HWSBY));

  // Serial, sync serial and converter lose state in standby
  assign serial_standby_clr = (state_r == ST_SBY);

  assign chip_reset = (state_r == ST_RESET) ||
                      (state_r == ST_HWSBY);
  assign hw_standby = (state_r == ST_HWSBY);

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // Captured in setup so the access phase sees a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      if (paddr == `PDM_ADDR_STOP_A) begin
        prdata <= {24'h000000, stop_a_r};
      end else if (paddr == `PDM_ADDR_STOP_B) begin
        prdata <= {24'h000000, stop_b_r};
      end else if (paddr == `PDM_ADDR_STOP_C) begin
        prdata <= {24'h000000, stop_c_r};
      end else if (paddr == `PDM_ADDR_CLK_CTRL) begin
        prdata <= {29'h00000000, clk_sel_r};
      end else if (paddr == `PDM_ADDR_SBY_CTRL) begin
        // Low three bits always read zero
        prdata <= {24'h000000, sby_sel_r, settle_r,
                   sby_rsv_r, 3'h0};
      end else if (paddr == `PDM_ADDR_STATUS) begin
        prdata <= {21'h000000, div_act_r,
                   2'h0, state_r};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

endmodule

// ---- verification/pdm_far_model.sv ----
// Far-side model: CPU bus cycle ends and peripheral access requests.
// Assumes one pclk domain and presetn active low, asynchronous.
`timescale 1ns/1ns

module pdm_far_model (
  input  wire        pclk,
  input  wire        presetn,
  output reg         bus_cycle_end,
  output reg  [23:0] periph_req
);
  reg [1:0] cnt_r; // Position within a four-state bus cycle

  // Bus cycle end pulse once every four clocks, requests from an LFSR
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r         <= 2'h0;
      bus_cycle_end <= 1'b0;
      periph_req    <= 24'h5a5a5a;
    end else begin
      cnt_r         <= cnt_r + 2'h1;
      bus_cycle_end <= (cnt_r == 2'h2);
      periph_req    <= {periph_req[22:0], periph_req[23] ^ periph_req[18]};
    end
  end
endmodule

// ---- verification/pdm_ctrl_monitor.sv ----
// Checker for the power-down controller, sees only its top ports.
// Assumes pclk rising edge and presetn active low, asynchronous.
`timescale 1ns/1ns

module pdm_ctrl_monitor (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pslverr,
  input logic        bus_cycle_end,
  input logic        nmi_req,
  input logic        reset_pin_n,
  input logic        wdt_overflow,
  input logic        hardware_standby_pin_n,
  input logic [23:0] periph_req,
  input logic [23:0] periph_grant,
  input logic [7:0]  module_stop_a,
  input logic [7:0]  module_stop_b,
  input logic [7:0]  module_stop_c,
  input logic        bm_clk_en,
  input logic        periph_clk_en,
  input logic        cpu_halt,
  input logic        osc_enable,
  input logic        serial_standby_clr,
  input logic        int_exc_start,
  input logic        reset_exc_start,
  input logic        chip_reset,
  input logic        hw_standby
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  grant_gate_a: assert property (periph_grant == (periph_req &
    ~{module_stop_c, module_stop_b, module_stop_a}))
    else $error("grant given to a stopped module");
  stop_hold_a: assert property (!bus_cycle_end && !chip_reset &&
    reset_pin_n && hardware_standby_pin_n && !wdt_overflow
    |=> $stable({module_stop_c, module_stop_b, module_stop_a}))
    else $error("stop bits changed off a bus cycle end");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
  sleep_wake_a: assert property (cpu_halt && periph_clk_en &&
    nmi_req && reset_pin_n && hardware_standby_pin_n && !wdt_overflow
    |=> int_exc_start && !cpu_halt) else $error("sleep not ended");
  rst_pin_a: assert property (!reset_pin_n && hardware_standby_pin_n
    |=> chip_reset && !hw_standby && osc_enable && periph_clk_en)
    else $error("reset pin not obeyed");
  hw_sby_a: assert property (!hardware_standby_pin_n
    |=> hw_standby && chip_reset && !osc_enable)
    else $error("standby pin not obeyed");
  sw_sby_a: assert property (serial_standby_clr
    |-> cpu_halt && !osc_enable && !periph_clk_en)
    else $error("software standby leaves clocks running");
  run_clk_a: assert property (bm_clk_en |-> !cpu_halt && !chip_reset)
    else $error("master clock while halted");
  run_per_a: assert property (!cpu_halt && !chip_reset
    |-> periph_clk_en) else $error("peripheral clock off while running");
  int_exc_a: assert property (int_exc_start
    |-> $past(cpu_halt) && !cpu_halt && !$past(int_exc_start))
    else $error("interrupt start without a wake");
  rst_exc_a: assert property (reset_exc_start
    |-> $past(chip_reset) && !chip_reset && !cpu_halt)
    else $error("reset start without reset release");
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the power-down controller over APB.
// Assumes the far-side model and the checker are compiled first.
`timescale 1ns/1ns

module tb;
  localparam int SB = 4; // Shortened settle base
  localparam logic [7:0] AM [3] = '{8'h7f, 8'hff, 8'hff}; // Keep-as-0 bits
  localparam logic [7:0] OM [3] = '{8'h04, 8'h1f, 8'heb}; // Keep-as-1 bits
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, module_stop_a, module_stop_b, module_stop_c;
  logic [31:0] pwdata, prdata, v, r, mdl [5];
  logic        bus_cycle_end, sleep_req, int_req, int_enabled, nmi_req;
  logic        cpu_int_masked, reset_pin_n, wdt_overflow, e;
  logic        hardware_standby_pin_n, bm_clk_en, periph_clk_en, cpu_halt;
  logic        osc_enable, serial_standby_clr, int_exc_start;
  logic        reset_exc_start, chip_reset, hw_standby;
  logic [5:0]  external_interrupt_lines, ext_int_enable, ext_int_to_xfer;
  logic [23:0] periph_req, periph_grant;
  int          err_total, num_checks, c, k, t, i, n;
  integer      seed;

  pdm_ctrl #(.SETTLE_BASE(20'd4)) i_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .bus_cycle_end,
    .sleep_req, .int_req, .int_enabled, .cpu_int_masked, .nmi_req,
    .external_interrupt_lines, .ext_int_enable, .ext_int_to_xfer,
    .reset_pin_n, .wdt_overflow, .hardware_standby_pin_n, .periph_req,
    .periph_grant, .module_stop_a, .module_stop_b, .module_stop_c,
    .bm_clk_en, .periph_clk_en, .cpu_halt, .osc_enable, .serial_standby_clr,
    .int_exc_start, .reset_exc_start, .chip_reset, .hw_standby);
  pdm_far_model i_far (.pclk, .presetn, .bus_cycle_end, .periph_req);

  // Clock generator, 10 ns period
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // --------------------------------------------------------------
  // Checking, bus and wait tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tmo;
    err_total++;
    give_verdict();
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int j;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (j = 0; j < 50; j++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (j == 50) tmo();
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic cyc(input int m);
    repeat (m) @(posedge pclk);
    #1;
  endtask
  task automatic wfor(input int w);
    int j;
    for (j = 0; j < 400; j++) begin
      cyc(1);
      if (w == 0 && int_exc_start === 1'b1) break;
      if (w == 1 && bus_cycle_end === 1'b1) break;
      if (w == 2 && reset_exc_start === 1'b1) break;
    end
    if (j == 400) tmo();
  endtask
  task automatic commit;
    wfor(1);
    cyc(1);
  endtask
  task automatic slp;
    @(posedge pclk);
    sleep_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
    #1;
  endtask
  task automatic cnt64(output int m);
    m = 0;
    repeat (64) begin
      cyc(1);
      m += bm_clk_en;
    end
  endtask
  task automatic rdall;
    v = {8'h0, mdl[2][7:0], mdl[1][7:0], mdl[0][7:0]};
    chk({module_stop_c, module_stop_b, module_stop_a}, v);
    for (k = 0; k < 5; k++) begin
      apb(1'b0, 8'(4 * k), 32'h0);
      chk(r, mdl[k]);
    end
  endtask
  task automatic mreset;
    mdl = '{32'h3f, 32'hff, 32'hff, 32'h0, 32'h08};
  endtask

  // Hang guard
  initial begin
    repeat (60000) @(posedge pclk);
    tmo();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    seed = 32'hbfb3dfe6;
    {err_total, num_checks} = '0;
    {presetn, psel, penable, pwrite, sleep_req, int_req} = '0;
    {int_enabled, cpu_int_masked, nmi_req, wdt_overflow} = '0;
    {reset_pin_n, hardware_standby_pin_n} = 2'b11;
    {external_interrupt_lines, ext_int_enable, ext_int_to_xfer} = '0;
    {paddr, pwdata} = '0;
    mreset();
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdall();
    apb(1'b0, 8'h18, 32'h0);
    chk({r[30:0], e}, 32'h1);
    apb(1'b1, 8'h14, 32'hffff);
    apb(1'b0, 8'h14, 32'h0);
    chk(r, 32'h1);
    $display("test 1 done");
    // Random stop patterns, spare bits kept as software must
    for (t = 0; t < 4; t++) begin
      for (c = 0; c < 3; c++) begin
        v = $random(seed);
        mdl[c] = {24'h0, (v[7:0] & AM[c]) | OM[c]};
        apb(1'b1, 8'(4 * c), mdl[c]);
      end
      commit();
      v = {8'h0, mdl[2][7:0], mdl[1][7:0], mdl[0][7:0]};
      chk(periph_grant, periph_req & ~v[23:0]);
      rdall();
    end
    $display("test 2 done");
    // Every divide code, ending at divide code 2 (divide by 4)
    for (c = 7; c >= 0; c--) begin
      apb(1'b1, 8'h0c, 32'(c));
      mdl[3] = 32'(c);
      commit();
      cnt64(n);
      chk(n, 64 >> ((c > 5) ? 5 : c));
    end
    apb(1'b1, 8'h0c, 32'h2);
    mdl[3] = 32'h2;
    commit();
    $display("test 3 done");
    // Sleep: masked, then disabled, then a real interrupt
    @(posedge pclk);
    {int_req, int_enabled, cpu_int_masked} <= 3'b111;
    slp();
    chk({cpu_halt, periph_clk_en}, 32'h3);
    @(posedge pclk);
    {int_enabled, cpu_int_masked} <= 2'b00;
    cyc(6);
    chk(cpu_halt, 1'b1);
    @(posedge pclk);
    int_enabled <= 1'b1;
    wfor(0);
    chk(cpu_halt, 1'b0);
    @(posedge pclk);
    {int_req, cpu_int_masked} <= 2'b01;
    slp();
    chk(cpu_halt, 1'b1);
    @(posedge pclk);
    nmi_req <= 1'b1;
    wfor(0);
    chk(cpu_halt, 1'b0);
    @(posedge pclk);
    {nmi_req, cpu_int_masked} <= 2'b00;
    cnt64(n);
    chk(n, 16);
    $display("test 4 done");
    // Software standby, refused wake, then timed settle
    for (c = 0; c < 7; c += 3) begin
      mdl[4] = 32'h88 | (c << 4);
      apb(1'b1, 8'h10, mdl[4]); // settle set by software
      @(posedge pclk);
      {external_interrupt_lines, ext_int_enable, ext_int_to_xfer} <= '1;
      slp();
      chk({osc_enable, serial_standby_clr}, 32'h1);
      cyc(6);
      chk(osc_enable, 1'b0);
      @(posedge pclk);
      if (c == 0) ext_int_to_xfer <= 6'h00;
      else nmi_req <= 1'b1;
      n = 0;
      for (i = 0; i < 400 && int_exc_start !== 1'b1; i++) begin
        cyc(1);
        n += (cpu_halt && osc_enable);
      end
      if (i == 400) tmo();
      chk(n, SB << ((c > 5) ? 5 : c));
      @(posedge pclk);
      {external_interrupt_lines, ext_int_enable, nmi_req} <= '0;
      rdall();
    end
    cnt64(n);
    chk(n, 16);
    $display("test 5 done");
    // Reset pin inside software standby
    slp();
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    cyc(2);
    chk({chip_reset, osc_enable}, 32'h3);
    @(posedge pclk);
    reset_pin_n <= 1'b1;
    wfor(2);
    mreset();
    rdall();
    // Standby pin from sleep, then watchdog in medium speed
    slp();
    @(posedge pclk);
    hardware_standby_pin_n <= 1'b0;
    cyc(2);
    chk({hw_standby, osc_enable, chip_reset}, 32'h5);
    @(posedge pclk);
    hardware_standby_pin_n <= 1'b1;
    wfor(2);
    apb(1'b1, 8'h0c, 32'h3);
    @(posedge pclk);
    wdt_overflow <= 1'b1;
    @(posedge pclk);
    wdt_overflow <= 1'b0;
    wfor(2);
    rdall();
    $display("test 6 done");
    give_verdict();
  end
endmodule

bind pdm_ctrl pdm_ctrl_monitor i_mon (.pclk, .presetn, .psel, .penable,
  .pslverr, .bus_cycle_end, .nmi_req, .reset_pin_n, .wdt_overflow,
  .hardware_standby_pin_n, .periph_req, .periph_grant, .module_stop_a,
  .module_stop_b, .module_stop_c, .bm_clk_en, .periph_clk_en, .cpu_halt,
  .osc_enable, .serial_standby_clr, .int_exc_start, .reset_exc_start,
  .chip_reset, .hw_standby);
